/* File: core/iihp_pkg.sv */
// shared constants and types for the isolated input host port
package iihp_pkg;
  localparam int CLK_FREQ_KHZ   = 100000;
  localparam int OSC_FREQ_KHZ   = 500;
  localparam int OSC_TICK_CYC   = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
  localparam int STARTUP_NS     = 160;
  localparam int STARTUP_CYC    = (STARTUP_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;
  localparam int HOST_WAIT_CYC  = 2 * STARTUP_CYC;
  localparam int PHASE_CYC      = 8;

  localparam logic [6:0] ADDR_INPUT_DATA = 7'h00;
  localparam logic [6:0] ADDR_DIAG_DATA  = 7'h01;
  localparam logic [6:0] ADDR_GERR       = 7'h02;
  localparam logic [6:0] ADDR_IERR       = 7'h03;
  localparam logic [6:0] ADDR_GCFG       = 7'h04;
  localparam int         BUS_DIR_BIT     = 7;

  localparam int         GERR_UV_BIT  = 0;
  localparam int         GERR_MV_BIT  = 1;
  localparam int         GERR_OC_BIT  = 2;
  localparam int         IERR_TE_BIT  = 0;
  localparam int         IERR_W4S_BIT = 1;
  localparam int         GCFG_DCK_BIT = 0;
  localparam logic [7:0] GERR_RESET   = 8'h03;
  localparam logic [7:0] IERR_RESET   = 8'h03;
  localparam logic [7:0] GCFG_RESET   = 8'h00;

  localparam logic [11:0] HREG_CTRL      = 12'h000;
  localparam logic [11:0] HREG_CMD       = 12'h004;
  localparam logic [11:0] HREG_STATUS    = 12'h008;
  localparam logic [11:0] HREG_INT_STAT  = 12'h00C;
  localparam logic [11:0] HREG_INT_MASK  = 12'h010;
  localparam int          CTRL_SERIAL_BIT = 0;
  localparam int          CTRL_FREEZE_BIT = 1;
  localparam int          CTRL_DRIVE_BIT  = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h2;
  localparam int          CMD_WRITE_BIT   = 7;
  localparam int          CMD_WDATA_LSB   = 8;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_FAULT_BIT  = 1;
  localparam int          STAT_RDATA_LSB  = 8;
  localparam int          INT_DONE_BIT    = 0;
  localparam int          INT_FAULT_BIT   = 1;

  typedef struct packed {
    logic       sel;
    logic       freeze;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       ale;
    logic       drive_en;
    logic [7:0] bus;
  } iihp_pins_t;

  localparam iihp_pins_t PINS_IDLE = '{sel: 1'b1, freeze: 1'b1, cs_n: 1'b1, rd_n: 1'b1,
                                       wr_n: 1'b1, ale: 1'b0, drive_en: 1'b0, bus: 8'hFF};

  typedef enum logic [3:0] {
    H_IDLE    = 4'b0001,
    H_ADDR    = 4'b0010,
    H_STROBE  = 4'b0100,
    H_RECOVER = 4'b1000
  } iihp_host_state_t;
endpackage

/* File: core/iihp_link_if.sv */
// pin-level link between the controller and the isolated input device
`timescale 1ns/1ns
interface iihp_link_if;
  logic       sel;
  logic       freeze;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       ale;
  logic       drive_en;
  logic [7:0] bus_host_o;
  logic       bus_host_oe_n;
  logic [7:0] bus_dev_o;
  logic       bus_dev_oe_n;
  logic       fault_o;
  logic       fault_oe_n;
  logic       sw_a_o;
  logic       sw_a_oe_n;
  logic       sw_b_o;
  logic       sw_b_oe_n;
  logic [7:0] muxed_bus;
  logic       fault_n;
  logic       switch_out_a;
  logic       switch_out_b;

  // wire levels; undriven lines read as pulled high
  assign muxed_bus    = !bus_dev_oe_n ? bus_dev_o : (!bus_host_oe_n ? bus_host_o : 8'hFF);
  assign fault_n      = fault_oe_n ? 1'b1 : fault_o;
  assign switch_out_a = sw_a_oe_n ? 1'b1 : sw_a_o;
  assign switch_out_b = sw_b_oe_n ? 1'b1 : sw_b_o;

  modport device (
    input  sel, freeze, cs_n, rd_n, wr_n, ale, drive_en, muxed_bus,
    output bus_dev_o, bus_dev_oe_n, fault_o, fault_oe_n, sw_a_o, sw_a_oe_n, sw_b_o, sw_b_oe_n
  );
  modport host (
    output sel, freeze, cs_n, rd_n, wr_n, ale, drive_en, bus_host_o, bus_host_oe_n,
    input  muxed_bus, fault_n, switch_out_a, switch_out_b
  );
endinterface

/* File: core/iihp_device.sv */
// device end: parallel register port, sample freeze, fault output and converter drive
// Notes on behaviour
// - select pin low means parallel interface
// - serial interface during start-up
// - host keeps select pin constant
// - freeze pin high updates registers each sample
// - falling freeze edge captures and freezes registers
// - freeze pin low holds registers
// - transfers only while chip select low
// - latch strobe high latches seven-bit address
// - address top bit: low read, high write
// - data transfers reuse latched address
// - active-low strobe starts a data transfer
// - any error flag pulls fault output low
// - no fault releases fault output
// - drive enable toggles switch outputs
// - divide bit halves switch frequency
// - host keeps drive enable constant
// - error register reads update bits, release fault
`timescale 1ns/1ns
module iihp_device
  import iihp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  iihp_link_if.device      link,
  input  wire logic [7:0]  raw_inputs,
  input  wire logic [7:0]  raw_diag,
  input  wire logic        sensor_uv,
  input  wire logic        supply_missing,
  input  wire logic        link_fail,
  input  wire logic        conv_overcurrent,
  output logic             parallel_mode,
  output logic             cfg_divide,
  output logic             fault_active,
  output logic [7:0]       input_data
);
  localparam int SU_W  = $clog2(STARTUP_CYC + 1);
  localparam int OSC_W = $clog2(OSC_TICK_CYC);
  localparam logic [SU_W-1:0]  SU_LAST  = SU_W'(STARTUP_CYC - 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_TICK_CYC - 1);

  iihp_pins_t      pin_s1_reg;
  iihp_pins_t      pin_s2_reg;
  iihp_pins_t      pin_d_reg;
  iihp_pins_t      pin_raw;
  logic [SU_W-1:0] su_cnt_reg;
  logic            started_reg;
  logic            parallel_reg;
  logic [OSC_W-1:0] osc_cnt_reg;
  logic            osc_tick;
  logic [7:0]      data_reg;
  logic [7:0]      diag_reg;
  logic            freeze_fall;
  logic            bus_en;
  logic [6:0]      addr_reg;
  logic            dir_write_reg;
  logic            rd_act;
  logic            rd_act_reg;
  logic            rd_end;
  logic            wr_act;
  logic            wr_act_reg;
  logic            wr_end;
  logic [7:0]      wdata_reg;
  logic [7:0]      rdata_reg;
  logic [7:0]      gerr_reg;
  logic [7:0]      gerr_set;
  logic [7:0]      ierr_reg;
  logic [7:0]      ierr_set;
  logic [7:0]      gcfg_reg;
  logic            fault_reg;
  logic            half_reg;
  logic            phase_reg;
  logic            sw_a_oe_n_reg;
  logic            sw_b_oe_n_reg;

  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] d,
                                          input logic [7:0] g, input logic [7:0] e,
                                          input logic [7:0] c, input logic [7:0] dg);
    if (a == ADDR_INPUT_DATA) begin
      return d;
    end else if (a == ADDR_DIAG_DATA) begin
      return dg;
    end else if (a == ADDR_GERR) begin
      return g;
    end else if (a == ADDR_IERR) begin
      return e;
    end else if (a == ADDR_GCFG) begin
      return c;
    end else begin
      return 8'h00;
    end
  endfunction

  assign pin_raw = '{sel: link.sel, freeze: link.freeze, cs_n: link.cs_n, rd_n: link.rd_n,
                     wr_n: link.wr_n, ale: link.ale, drive_en: link.drive_en,
                     bus: link.muxed_bus};

  // two-stage synchroniser on every pin, plus a delayed copy for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= PINS_IDLE;
      pin_s2_reg <= PINS_IDLE;
      pin_d_reg  <= PINS_IDLE;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end

  // start-up: serial until the strap is caught at the end of start-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      su_cnt_reg   <= '0;
      started_reg  <= 1'b0;
      parallel_reg <= 1'b0;
    end else if (!started_reg) begin
      su_cnt_reg <= su_cnt_reg + 1'b1;
      if (su_cnt_reg == SU_LAST) begin
        started_reg  <= 1'b1;
        parallel_reg <= !pin_s2_reg.sel;
      end
    end
  end

  // internal sampling clock as an enable pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_cnt_reg <= '0;
    end else if (osc_tick) begin
      osc_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 1'b1;
    end
  end
  assign osc_tick = (osc_cnt_reg == OSC_LAST);

  assign freeze_fall = pin_d_reg.freeze && !pin_s2_reg.freeze;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_reg <= 8'h00;
      diag_reg <= 8'h00;
    end else if (pin_s2_reg.freeze ? osc_tick : freeze_fall) begin
      data_reg <= raw_inputs;
      diag_reg <= raw_diag;
    end
  end

  assign bus_en = parallel_reg && !pin_s2_reg.cs_n;
  assign rd_act = bus_en && !pin_s2_reg.ale && !pin_s2_reg.rd_n && !dir_write_reg;
  assign wr_act = bus_en && !pin_s2_reg.ale && !pin_s2_reg.wr_n && dir_write_reg;
  assign rd_end = rd_act_reg && !rd_act;
  assign wr_end = wr_act_reg && !wr_act;

  // address phase latches address and direction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg      <= ADDR_INPUT_DATA;
      dir_write_reg <= 1'b0;
    end else if (bus_en && pin_s2_reg.ale) begin
      addr_reg      <= pin_s2_reg.bus[6:0];
      dir_write_reg <= pin_s2_reg.bus[BUS_DIR_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      wdata_reg  <= 8'h00;
      rdata_reg  <= 8'h00;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
      rdata_reg  <= reg_read(addr_reg, data_reg, gerr_reg, ierr_reg, gcfg_reg, diag_reg);
      if (wr_act) begin
        wdata_reg <= pin_s2_reg.bus;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gcfg_reg <= GCFG_RESET;
    end else if (wr_end && addr_reg == ADDR_GCFG) begin
      gcfg_reg <= wdata_reg;
    end
  end

  always_comb begin
    gerr_set = 8'h00;
    gerr_set[GERR_UV_BIT] = sensor_uv;
    gerr_set[GERR_MV_BIT] = supply_missing;
    gerr_set[GERR_OC_BIT] = conv_overcurrent;
    ierr_set = 8'h00;
    ierr_set[IERR_TE_BIT] = link_fail;
  end

  // error bits stay set until read; a live condition wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gerr_reg <= GERR_RESET;
      ierr_reg <= IERR_RESET;
    end else begin
      gerr_reg <= gerr_set | ((rd_end && addr_reg == ADDR_GERR) ? 8'h00 : gerr_reg);
      ierr_reg <= ierr_set | ((rd_end && addr_reg == ADDR_IERR) ? 8'h00 : ierr_reg);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_reg <= 1'b1;
    end else begin
      fault_reg <= (|gerr_reg) || (|ierr_reg) || conv_overcurrent;
    end
  end

  // converter drive: toggle per oscillator tick, every other tick when divided
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_reg  <= 1'b0;
      phase_reg <= 1'b0;
    end else if (osc_tick) begin
      half_reg <= !half_reg;
      if (!gcfg_reg[GCFG_DCK_BIT] || half_reg) begin
        phase_reg <= !phase_reg;
      end
    end
  end

  // overcurrent turns the switches off until it clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_a_oe_n_reg <= 1'b1;
      sw_b_oe_n_reg <= 1'b1;
    end else begin
      sw_a_oe_n_reg <= !(pin_s2_reg.drive_en && !conv_overcurrent && !phase_reg);
      sw_b_oe_n_reg <= !(pin_s2_reg.drive_en && !conv_overcurrent && phase_reg);
    end
  end

  assign link.bus_dev_o    = rdata_reg;
  assign link.bus_dev_oe_n = !(rd_act_reg && rd_act);
  assign link.fault_o      = 1'b0;
  assign link.fault_oe_n   = !fault_reg;
  assign link.sw_a_o       = 1'b0;
  assign link.sw_a_oe_n    = sw_a_oe_n_reg;
  assign link.sw_b_o       = 1'b0;
  assign link.sw_b_oe_n    = sw_b_oe_n_reg;
  assign parallel_mode     = parallel_reg;
  assign cfg_divide        = gcfg_reg[GCFG_DCK_BIT];
  assign fault_active      = fault_reg;
  assign input_data        = data_reg;
endmodule // iihp_device

/* File: core/iihp_host.sv */
// controller end: apb register block driving the multiplexed device port
`timescale 1ns/1ns
module iihp_host
  import iihp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  iihp_link_if.host        link
);
  localparam int PH_W = $clog2(PHASE_CYC);
  localparam int HW_W = $clog2(HOST_WAIT_CYC + 1);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(PHASE_CYC - 1);
  localparam logic [HW_W-1:0] HW_LAST = HW_W'(HOST_WAIT_CYC);

  iihp_host_state_t state_reg;
  logic [PH_W-1:0]  ph_cnt_reg;
  logic [HW_W-1:0]  wait_cnt_reg;
  logic [1:0]       init_step_reg;
  logic [2:0]       ctrl_reg;
  logic             locked_reg;
  logic             pend_reg;
  logic [6:0]       cmd_addr_reg;
  logic             cmd_write_reg;
  logic [7:0]       cmd_wdata_reg;
  logic [7:0]       rdata_reg;
  logic [7:0]       bus_s1_reg;
  logic [7:0]       bus_s2_reg;
  logic             fault_s1_reg;
  logic             fault_s2_reg;
  logic             fault_d_reg;
  logic [1:0]       int_stat_reg;
  logic [1:0]       int_mask_reg;
  logic [1:0]       int_set;
  logic             pready_reg;
  logic [31:0]      prdata_reg;
  logic             slverr_reg;
  logic             access;
  logic             init_done;
  logic             launch;
  logic             ph_end;
  logic             cs_n_reg;
  logic             ale_reg;
  logic             rd_n_reg;
  logic             wr_n_reg;
  logic [7:0]       bus_o_reg;
  logic             bus_oe_n_reg;

  assign access    = psel && penable && pready_reg;
  assign init_done = (init_step_reg == 2'd2);
  assign launch    = (state_reg == H_IDLE) && (wait_cnt_reg == HW_LAST) && (pend_reg || !init_done);
  assign ph_end    = (ph_cnt_reg == PH_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_s1_reg   <= 8'hFF;
      bus_s2_reg   <= 8'hFF;
      fault_s1_reg <= 1'b1;
      fault_s2_reg <= 1'b1;
      fault_d_reg  <= 1'b1;
    end else begin
      bus_s1_reg   <= link.muxed_bus;
      bus_s2_reg   <= bus_s1_reg;
      fault_s1_reg <= link.fault_n;
      fault_s2_reg <= fault_s1_reg;
      fault_d_reg  <= fault_s2_reg;
    end
  end

  // wait past device start-up before the first transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt_reg <= '0;
    end else if (wait_cnt_reg != HW_LAST) begin
      wait_cnt_reg <= wait_cnt_reg + 1'b1;
    end
  end

  // apb slave, one wait state per access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      slverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      if (psel && penable && !pready_reg) begin
        if (paddr == HREG_CTRL) begin
          prdata_reg[2:0] <= ctrl_reg;
        end else if (paddr == HREG_CMD) begin
          prdata_reg[CMD_WRITE_BIT:0] <= {cmd_write_reg, cmd_addr_reg};
          prdata_reg[CMD_WDATA_LSB +: 8] <= cmd_wdata_reg;
        end else if (paddr == HREG_STATUS) begin
          prdata_reg[STAT_BUSY_BIT]      <= pend_reg || !init_done || (state_reg != H_IDLE);
          prdata_reg[STAT_FAULT_BIT]     <= !fault_s2_reg;
          prdata_reg[STAT_RDATA_LSB +: 8] <= rdata_reg;
        end else if (paddr == HREG_INT_STAT) begin
          prdata_reg[1:0] <= int_stat_reg;
        end else if (paddr == HREG_INT_MASK) begin
          prdata_reg[1:0] <= int_mask_reg;
        end else begin
          slverr_reg <= 1'b1;
        end
      end
    end
  end

  // strap and drive enable freeze once the first transfer starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= CTRL_RESET;
      locked_reg <= 1'b0;
    end else begin
      if (launch) begin
        locked_reg <= 1'b1;
      end
      if (access && pwrite && paddr == HREG_CTRL) begin
        ctrl_reg[CTRL_FREEZE_BIT] <= pwdata[CTRL_FREEZE_BIT];
        if (!locked_reg && !launch) begin
          ctrl_reg[CTRL_SERIAL_BIT] <= pwdata[CTRL_SERIAL_BIT];
          ctrl_reg[CTRL_DRIVE_BIT]  <= pwdata[CTRL_DRIVE_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_mask_reg <= 2'b00;
    end else if (access && pwrite && paddr == HREG_INT_MASK) begin
      int_mask_reg <= pwdata[1:0];
    end
  end

  always_comb begin
    int_set = 2'b00;
    int_set[INT_DONE_BIT]  = (state_reg == H_RECOVER) && ph_end;
    int_set[INT_FAULT_BIT] = fault_d_reg && !fault_s2_reg;
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_stat_reg <= 2'b00;
    end else if (access && pwrite && paddr == HREG_INT_STAT) begin
      int_stat_reg <= int_set | (int_stat_reg & ~pwdata[1:0]);
    end else begin
      int_stat_reg <= int_set | int_stat_reg;
    end
  end

  // command queue; commands written while one is still pending, or in a launch cycle, are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_reg      <= 1'b0;
      cmd_addr_reg  <= 7'h00;
      cmd_write_reg <= 1'b0;
      cmd_wdata_reg <= 8'h00;
      init_step_reg <= 2'd0;
    end else if (launch) begin
      if (init_done) begin
        pend_reg <= 1'b0;
      end else begin
        init_step_reg <= init_step_reg + 2'd1;
      end
    end else if (access && pwrite && paddr == HREG_CMD && !pend_reg) begin
      pend_reg      <= 1'b1;
      cmd_addr_reg  <= pwdata[6:0];
      cmd_write_reg <= pwdata[CMD_WRITE_BIT];
      cmd_wdata_reg <= pwdata[CMD_WDATA_LSB +: 8];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= H_IDLE;
      ph_cnt_reg   <= '0;
      cs_n_reg     <= 1'b1;
      ale_reg      <= 1'b0;
      rd_n_reg     <= 1'b1;
      wr_n_reg     <= 1'b1;
      bus_o_reg    <= 8'h00;
      bus_oe_n_reg <= 1'b1;
      rdata_reg    <= 8'h00;
    end else begin
      ph_cnt_reg <= (state_reg == H_IDLE || ph_end) ? '0 : ph_cnt_reg + 1'b1;
      case (state_reg)
        H_IDLE: begin
          if (launch) begin
            cs_n_reg     <= 1'b0;
            ale_reg      <= 1'b1;
            bus_oe_n_reg <= 1'b0;
            if (init_done) begin
              bus_o_reg <= {cmd_write_reg, cmd_addr_reg};
            end else begin
              bus_o_reg <= {1'b0, (init_step_reg == 2'd0) ? ADDR_GERR : ADDR_IERR};
            end
            state_reg <= H_ADDR;
          end
        end
        H_ADDR: begin
          if (ph_end) begin
            ale_reg <= 1'b0;
            if (bus_o_reg[BUS_DIR_BIT]) begin
              wr_n_reg  <= 1'b0;
              bus_o_reg <= cmd_wdata_reg;
            end else begin
              rd_n_reg     <= 1'b0;
              bus_oe_n_reg <= 1'b1;
            end
            state_reg <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (ph_end) begin
            if (!rd_n_reg) begin
              rdata_reg <= bus_s2_reg;
            end
            rd_n_reg  <= 1'b1;
            wr_n_reg  <= 1'b1;
            state_reg <= H_RECOVER;
          end
        end
        H_RECOVER: begin
          if (ph_end) begin
            cs_n_reg     <= 1'b1;
            bus_oe_n_reg <= 1'b1;
            state_reg    <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign link.sel           = ctrl_reg[CTRL_SERIAL_BIT];
  assign link.freeze        = ctrl_reg[CTRL_FREEZE_BIT];
  assign link.drive_en      = ctrl_reg[CTRL_DRIVE_BIT];
  assign link.cs_n          = cs_n_reg;
  assign link.ale           = ale_reg;
  assign link.rd_n          = rd_n_reg;
  assign link.wr_n          = wr_n_reg;
  assign link.bus_host_o    = bus_o_reg;
  assign link.bus_host_oe_n = bus_oe_n_reg;
  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = slverr_reg && pready_reg;
  assign irq                = |(int_stat_reg & int_mask_reg);
endmodule // iihp_host

/* File: verif/iihp_asserts.sv */
// concurrent checks on the controller to device link
`timescale 1ns/1ns
module iihp_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       ale,
  input wire logic       drive_en,
  input wire logic [7:0] muxed_bus,
  input wire logic       bus_dev_oe_n,
  input wire logic       fault_oe_n,
  input wire logic       sw_a_oe_n,
  input wire logic       sw_b_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_addr;
    ale[*8] ##1 (!ale && (!rd_n || !wr_n));
  endsequence
  sequence s_read;
    (!rd_n)[*8] ##1 rd_n;
  endsequence
  chk_bus_read_only: assert property (!bus_dev_oe_n |-> !cs_n && !ale)
    else $error("device drives bus outside a read");
  chk_no_write_drive: assert property (!wr_n |-> bus_dev_oe_n)
    else $error("device drives bus during a write");
  chk_strobe_in_cs: assert property ((!rd_n || !wr_n) |-> !cs_n && !ale)
    else $error("strobe without chip select");
  chk_addr_phase: assert property ($fell(cs_n) |-> s_addr)
    else $error("address phase length wrong");
  chk_read_strobe: assert property ($fell(rd_n) |-> s_read)
    else $error("read strobe length wrong");
  chk_dir_bit: assert property ($fell(ale) |-> (!wr_n == $past(muxed_bus[7])))
    else $error("strobe does not match direction bit");
  chk_switch_idle: assert property ((!drive_en)[*4] |-> sw_a_oe_n && sw_b_oe_n)
    else $error("switch driven while disabled");
  chk_switch_steady: assert property ($changed(sw_a_oe_n) |=> $stable(sw_a_oe_n)[*8])
    else $error("switch toggles too fast");
  chk_fault_release: assert property ($rose(fault_oe_n) |-> !cs_n)
    else $error("fault released outside a transfer");
endmodule // iihp_asserts

/* File: verif/isolated_input_host_port_tb.sv */
// self-checking bench joining controller and device ends
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module isolated_input_host_port_tb;
  import iihp_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [3:0]  err_in = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 32'h20da_9ae4;
  logic        pready, pslverr, irq, parallel_mode, cfg_divide, fault_active;
  logic [7:0]  raw_inputs = 0, a_val, input_data;
  logic [32:0] expq[$];
  int          miscompares = 0, check_count = 0;
  iihp_link_if link();
  iihp_host iihp_host_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  iihp_device iihp_device_inst (.clk(clk), .rst(rst), .link(link), .raw_inputs(raw_inputs),
    .raw_diag(~raw_inputs), .sensor_uv(err_in[0]), .supply_missing(err_in[1]),
    .link_fail(err_in[2]), .conv_overcurrent(err_in[3]), .parallel_mode(parallel_mode),
    .cfg_divide(cfg_divide), .fault_active(fault_active), .input_data(input_data));
  iihp_asserts iihp_asserts_inst (.clk(clk), .rst(rst), .cs_n(link.cs_n), .rd_n(link.rd_n),
    .wr_n(link.wr_n), .ale(link.ale), .drive_en(link.drive_en), .muxed_bus(link.muxed_bus),
    .bus_dev_oe_n(link.bus_dev_oe_n), .fault_oe_n(link.fault_oe_n),
    .sw_a_oe_n(link.sw_a_oe_n), .sw_b_oe_n(link.sw_b_oe_n));
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); end while (pready !== 1'b1);
    psel <= 0; penable <= 0;
  endtask
  task automatic dev(input logic [6:0] a, input logic w, input logic [7:0] d,
                     input logic [7:0] e);
    apb(HREG_CMD, 1, {16'h0000, d, w, a}, 0);
    while (irq !== 1'b1) @(posedge clk);
    apb(HREG_INT_STAT, 1, 32'h0000_0003, 0);
    if (!w) apb(HREG_STATUS, 0, 0, {1'b0, 16'h0000, e, 8'h00});
  endtask
  task automatic measure(input int e);
    int n;
    logic v;
    repeat (2) begin
      v = link.switch_out_a;
      while (link.switch_out_a === v) @(posedge clk);
    end
    n = 0;
    v = link.switch_out_a;
    while (link.switch_out_a === v && n < 1000) begin @(posedge clk); n++; end
    `CHK(n, e)
    `CHK(link.switch_out_b, !link.switch_out_a)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    seed <= lfsr(seed);
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      `CHK({pslverr, prdata}, expq.pop_front())
  end
  initial begin
    #200000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    `CHK(parallel_mode, 1'b0)
    apb(HREG_CTRL, 0, 0, {1'b0, 32'h0000_0002});
    apb(HREG_CTRL, 1, 32'h0000_0006, 0);
    apb(12'hFFC, 0, 0, {1'b1, 32'h0000_0000});
    repeat (150) @(posedge clk);
    `CHK(parallel_mode, 1'b1)
    `CHK(link.fault_n, 1'b1)
    `CHK(irq, 1'b0)
    apb(HREG_INT_STAT, 1, 32'h0000_0003, 0);
    apb(HREG_INT_MASK, 1, 32'h0000_0001, 0);
    a_val = seed[7:0];
    raw_inputs <= a_val;
    repeat (450) @(posedge clk);
    raw_inputs <= ~a_val;
    apb(HREG_CTRL, 1, 32'h0000_0004, 0);
    dev(ADDR_INPUT_DATA, 0, 0, ~a_val);
    `CHK(input_data, ~a_val)
    raw_inputs <= a_val;
    repeat (450) @(posedge clk);
    dev(ADDR_INPUT_DATA, 0, 0, ~a_val);
    apb(HREG_CTRL, 1, 32'h0000_0006, 0);
    repeat (450) @(posedge clk);
    dev(ADDR_INPUT_DATA, 0, 0, a_val);
    dev(ADDR_DIAG_DATA, 0, 0, ~a_val);
    measure(OSC_TICK_CYC);
    dev(ADDR_GCFG, 1, 8'h01, 0);
    `CHK(cfg_divide, 1'b1)
    dev(ADDR_GCFG, 0, 0, 8'h01);
    dev(7'h05, 0, 0, 8'h00);
    measure(2 * OSC_TICK_CYC);
    repeat (10) @(posedge clk);
    err_in <= 4'hB;
    repeat (10) @(posedge clk);
    `CHK({link.switch_out_a, link.switch_out_b}, 2'h3)
    err_in <= 4'h0;
    repeat (10) @(posedge clk);
    `CHK(link.fault_n, 1'b0)
    apb(HREG_INT_STAT, 0, 0, {1'b0, 32'h0000_0002});
    dev(ADDR_GERR, 0, 0, 8'h07);
    `CHK(link.fault_n, 1'b1)
    err_in <= 4'h4;
    @(posedge clk);
    err_in <= 4'h0;
    repeat (10) @(posedge clk);
    `CHK(fault_active, 1'b1)
    dev(ADDR_IERR, 0, 0, 8'h01);
    `CHK(fault_active, 1'b0)
    finish_test;
  end
endmodule // isolated_input_host_port_tb
